/* hw/rcs_top.sv */
// Local timebase generator, timebase select, event pass-through, indicators.
// Assumes all pin inputs are asynchronous to ref_clk; APB on ref_clk.
`timescale 1ns/1ps
`include "rcs_defines.svh"
`default_nettype none

module rcs_top #(
	parameter int HIGH_CYC  = `RCS_HIGH_CYC,
	parameter int LOW_CYC   = `RCS_LOW_CYC,
	parameter int STUCK_CYC = `RCS_STUCK_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        setup_strobe_n,
	input  wire logic [7:0]  setup_bus,
	input  wire logic        host_sync,
	input  wire logic        partner_sync,
	input  wire logic        ext_ref_clk,
	input  wire logic        ext_event,
	output logic             timebase_clock,
	output logic             experiment_timebase,
	output logic             event_out,
	output logic      [1:0]  led_generator,
	output logic      [1:0]  led_host_sync,
	output logic      [1:0]  led_partner_sync,
	output logic      [1:0]  led_int_clock,
	output logic      [1:0]  led_ext_clock,
	output logic      [1:0]  led_event
);

	localparam int IN_W = 13;
	localparam int B_STRB  = 8;
	localparam int B_HSYNC = 9;
	localparam int B_PSYNC = 10;
	localparam int B_EVENT = 11;
	localparam int B_EXTCK = 12;
	// Strobe stages reset to its idle high level; resetting them low
	// would show a false rising edge just after reset
	localparam logic [IN_W-1:0] SYNC_IDLE = IN_W'(1) << B_STRB;

	// Pin synchronisers
	logic [IN_W-1:0] async_in;
	logic [IN_W-1:0] sync1_r;
	logic [IN_W-1:0] sync2_r;

	assign async_in = {ext_ref_clk, ext_event, partner_sync, host_sync,
		setup_strobe_n, setup_bus};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_r <= SYNC_IDLE;
			sync2_r <= SYNC_IDLE;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	logic host_run;
	logic partner_run;
	logic strobe_s;
	logic event_s;
	logic ext_clk_s;
	assign host_run    = sync2_r[B_HSYNC];
	assign partner_run = sync2_r[B_PSYNC];
	assign strobe_s    = sync2_r[B_STRB];
	assign event_s     = sync2_r[B_EVENT];
	assign ext_clk_s   = sync2_r[B_EXTCK];

	// Local timebase generator
	rcs_pkg::rcs_phase_e      ph_r;
	rcs_pkg::rcs_phase_e      ph_nxt;
	logic [`RCS_CNT_W-1:0]    gcnt_r;
	logic [`RCS_CNT_W-1:0]    gcnt_nxt;
	logic                     gen_r;
	logic                     gen_nxt;

	always_comb begin
		ph_nxt   = ph_r;
		gcnt_nxt = gcnt_r + `RCS_CNT_W'(1);
		case (ph_r)
			rcs_pkg::RCS_PH_HIGH: begin
				if (gcnt_r == `RCS_CNT_W'(HIGH_CYC - 1)) begin
					ph_nxt   = rcs_pkg::RCS_PH_LOW;
					gcnt_nxt = '0;
				end
			end
			rcs_pkg::RCS_PH_LOW: begin
				if (gcnt_r == `RCS_CNT_W'(LOW_CYC - 1)) begin
					ph_nxt   = rcs_pkg::RCS_PH_HIGH;
					gcnt_nxt = '0;
				end
			end
			default: begin
				ph_nxt   = rcs_pkg::RCS_PH_HIGH;
				gcnt_nxt = '0;
			end
		endcase
		gen_nxt = (ph_nxt == rcs_pkg::RCS_PH_HIGH);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ph_r   <= rcs_pkg::RCS_PH_HIGH;
			gcnt_r <= '0;
			gen_r  <= 1'b1;
		end else begin
			ph_r   <= ph_nxt;
			gcnt_r <= gcnt_nxt;
			gen_r  <= gen_nxt;
		end
	end

	// Clock health monitors: 0 internal, 1 external
	logic [1:0]            mon_in;
	logic [1:0]            mon_prev_r;
	logic [1:0]            mon_stuck_r;
	logic [1:0]            mon_lvl_r;
	logic [`RCS_CNT_W-1:0] mon_cnt_r [2];

	assign mon_in = {ext_clk_s, gen_r};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_mon
			logic                  stuck_nxt;
			logic                  lvl_nxt;
			logic [`RCS_CNT_W-1:0] cnt_nxt;
			always_comb begin
				stuck_nxt = mon_stuck_r[gi];
				lvl_nxt   = mon_in[gi];
				cnt_nxt   = mon_cnt_r[gi];
				if (mon_in[gi] != mon_prev_r[gi]) begin
					cnt_nxt   = '0;
					stuck_nxt = 1'b0;
				end else if (mon_cnt_r[gi] == `RCS_CNT_W'(STUCK_CYC - 1)) begin
					stuck_nxt = 1'b1;
				end else begin
					cnt_nxt = mon_cnt_r[gi] + `RCS_CNT_W'(1);
				end
			end
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					mon_prev_r[gi]  <= 1'b0;
					mon_stuck_r[gi] <= 1'b0;
					mon_lvl_r[gi]   <= 1'b0;
					mon_cnt_r[gi]   <= '0;
				end else begin
					mon_prev_r[gi]  <= mon_in[gi];
					mon_stuck_r[gi] <= stuck_nxt;
					mon_lvl_r[gi]   <= lvl_nxt;
					mon_cnt_r[gi]   <= cnt_nxt;
				end
			end
		end
	endgenerate

	// Setup bus write; bus passes the same two stages as the strobe,
	// so a bus held stable across the pulse is caught intact
	logic strobe_prev_r;
	logic sel_ext_r;
	logic sel_ext_nxt;
	logic pol_r;
	logic pol_nxt;
	logic take_setup;

	assign take_setup = strobe_s && !strobe_prev_r
		&& sync2_r[`RCS_SET_ARM]
		&& !host_run;

	always_comb begin
		sel_ext_nxt = sel_ext_r;
		pol_nxt     = pol_r;
		if (take_setup) begin
			sel_ext_nxt = sync2_r[`RCS_SET_SEL];
			pol_nxt     = sync2_r[`RCS_SET_POL];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strobe_prev_r <= 1'b1;
			sel_ext_r     <= `RCS_SEL_RST;
			pol_r         <= `RCS_POL_RST;
		end else begin
			strobe_prev_r <= strobe_s;
			sel_ext_r     <= sel_ext_nxt;
			pol_r         <= pol_nxt;
		end
	end

	// APB slave, one wait state per access
	logic        blank_r;
	logic        blank_nxt;
	logic [31:0] prdata_nxt;
	logic        pready_nxt;
	logic        pslverr_nxt;
	logic [31:0] status_w;
	logic        event_nxt;

	always_comb begin
		status_w = '0;
		status_w[`RCS_ST_SEL]    = sel_ext_r;
		status_w[`RCS_ST_POL]    = pol_r;
		status_w[`RCS_ST_HSYNC]  = host_run;
		status_w[`RCS_ST_PSYNC]  = partner_run;
		status_w[`RCS_ST_ISTUCK] = mon_stuck_r[0];
		status_w[`RCS_ST_ILVL]   = mon_lvl_r[0];
		status_w[`RCS_ST_ESTUCK] = mon_stuck_r[1];
		status_w[`RCS_ST_ELVL]   = mon_lvl_r[1];
		status_w[`RCS_ST_EVENT]  = event_out;
	end

	always_comb begin
		blank_nxt   = blank_r;
		prdata_nxt  = '0;
		pslverr_nxt = 1'b0;
		pready_nxt  = psel && penable && !pready;
		if (psel && penable && !pready) begin
			if (paddr == `RCS_OFF_CTRL) begin
				prdata_nxt[`RCS_CTRL_BLANK] = blank_r;
			end else if (paddr == `RCS_OFF_STATUS) begin
				prdata_nxt = status_w;
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
		if (psel && penable && pready && pwrite
				&& paddr == `RCS_OFF_CTRL) begin
			blank_nxt = pwdata[`RCS_CTRL_BLANK];
		end
	end

	// Output stage; indicators go dark while blanked
	function automatic rcs_pkg::rcs_led_t health_led(input logic stuck,
			input logic lvl);
		if (!stuck) begin
			health_led = `RCS_LED_AMBER;
		end else if (lvl) begin
			health_led = `RCS_LED_RED;
		end else begin
			health_led = `RCS_LED_GREEN;
		end
	endfunction

	function automatic rcs_pkg::rcs_led_t run_led(input logic run,
			input logic blank);
		if (blank) begin
			run_led = `RCS_LED_OFF;
		end else if (run) begin
			run_led = `RCS_LED_GREEN;
		end else begin
			run_led = `RCS_LED_RED;
		end
	endfunction

	assign event_nxt = pol_r ? event_s : !event_s;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			blank_r             <= 1'b0;
			prdata              <= '0;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			timebase_clock      <= 1'b0;
			experiment_timebase <= 1'b0;
			event_out           <= 1'b0;
			led_generator       <= `RCS_LED_OFF;
			led_host_sync       <= `RCS_LED_OFF;
			led_partner_sync    <= `RCS_LED_OFF;
			led_int_clock       <= `RCS_LED_OFF;
			led_ext_clock       <= `RCS_LED_OFF;
			led_event           <= `RCS_LED_OFF;
		end else begin
			blank_r             <= blank_nxt;
			prdata              <= prdata_nxt;
			pready              <= pready_nxt;
			pslverr             <= pslverr_nxt;
			timebase_clock      <= gen_r;
			experiment_timebase <= sel_ext_r ? ext_clk_s : gen_r;
			event_out           <= event_nxt;
			led_generator       <= blank_r ? `RCS_LED_OFF
				: health_led(mon_stuck_r[0], mon_lvl_r[0]);
			led_host_sync       <= run_led(host_run, blank_r);
			led_partner_sync    <= run_led(partner_run, blank_r);
			led_int_clock       <= (blank_r || sel_ext_r) ? `RCS_LED_OFF
				: health_led(mon_stuck_r[0], mon_lvl_r[0]);
			led_ext_clock       <= (blank_r || !sel_ext_r) ? `RCS_LED_OFF
				: health_led(mon_stuck_r[1], mon_lvl_r[1]);
			led_event           <= run_led(!event_out, blank_r);
		end
	end

endmodule

`default_nettype wire

/* hw/rcs_defines.svh */
// Constants for the reference clock select and status block.
// Assumes a 100 MHz board clock; counts are derived from times in ns.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_CLK_NS         10
`define RCS_HIGH_NS        2000
`define RCS_LOW_NS         2125
`define RCS_PERIOD_NS      4125
`define RCS_STUCK_PERIODS  4
// Least times round up to whole cycles
`define RCS_HIGH_CYC  ((`RCS_HIGH_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_LOW_CYC   ((`RCS_LOW_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_STUCK_CYC ((`RCS_STUCK_PERIODS * `RCS_PERIOD_NS) / `RCS_CLK_NS)
`define RCS_CNT_W     12

`define RCS_OFF_CTRL   8'h00
`define RCS_OFF_STATUS 8'h04

`define RCS_CTRL_BLANK 0
`define RCS_ST_SEL     0
`define RCS_ST_POL     1
`define RCS_ST_HSYNC   2
`define RCS_ST_PSYNC   3
`define RCS_ST_ISTUCK  4
`define RCS_ST_ILVL    5
`define RCS_ST_ESTUCK  6
`define RCS_ST_ELVL    7
`define RCS_ST_EVENT   8

`define RCS_SET_ARM    7
`define RCS_SET_SEL    0
`define RCS_SET_POL    1

`define RCS_SEL_RST    1'b0
`define RCS_POL_RST    1'b1

`define RCS_LED_OFF    2'h0
`define RCS_LED_GREEN  2'h1
`define RCS_LED_RED    2'h2
`define RCS_LED_AMBER  2'h3

`endif

/* hw/rcs_pkg.sv */
// Types for the reference clock select and status block.
// Constants live in rcs_defines.svh.
package rcs_pkg;
	typedef logic [1:0] rcs_led_t;
	typedef enum logic {RCS_PH_HIGH, RCS_PH_LOW} rcs_phase_e;
endpackage

/* verif/rcs_checker.sv */
// Port checker for rcs_top.
// Sees only the top ports; bound into every rcs_top.
`timescale 1ns/1ps
`include "rcs_defines.svh"
`default_nettype none
module rcs_checker #(
	parameter int HIGH_CYC = 5,
	parameter int LOW_CYC  = 6
) (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        host_sync,
	input wire logic        partner_sync,
	input wire logic        timebase_clock,
	input wire logic        experiment_timebase,
	input wire logic        ext_ref_clk,
	input wire logic        event_out,
	input wire logic [1:0]  led_generator,
	input wire logic [1:0]  led_host_sync,
	input wire logic [1:0]  led_partner_sync,
	input wire logic [1:0]  led_int_clock,
	input wire logic [1:0]  led_ext_clock,
	input wire logic [1:0]  led_event
);
	logic        prev_r;
	logic [11:0] run_r;
	logic [11:0] run_nxt;
	// Run length stays 0 until the first edge, so reset time is not timed
	always_comb begin
		run_nxt = run_r + 12'h001;
		if (rst)
			run_nxt = 12'h000;
		else if (timebase_clock != prev_r)
			run_nxt = 12'h001;
		else if (run_r == 12'h000)
			run_nxt = 12'h000;
	end
	always_ff @(posedge ref_clk) begin
		prev_r <= timebase_clock;
		run_r  <= run_nxt;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_gen_high: assert property ($fell(timebase_clock) |-> run_r == HIGH_CYC)
		else $error("timebase high time wrong");
	a_gen_low: assert property ($rose(timebase_clock) && run_r != 12'h000
		|-> run_r == LOW_CYC) else $error("timebase low time wrong");
	a_gen_amber: assert property ($rose(timebase_clock) ##1
		led_generator != `RCS_LED_OFF |-> led_generator == `RCS_LED_AMBER)
		else $error("generator indicator wrong");
	a_host_led: assert property ($stable(host_sync)[*5] ##0
		led_host_sync != `RCS_LED_OFF |-> led_host_sync ==
		(host_sync ? `RCS_LED_GREEN : `RCS_LED_RED))
		else $error("host sync indicator wrong");
	a_partner_led: assert property ($stable(partner_sync)[*5] ##0
		led_partner_sync != `RCS_LED_OFF |-> led_partner_sync ==
		(partner_sync ? `RCS_LED_GREEN : `RCS_LED_RED))
		else $error("partner sync indicator wrong");
	a_event_led: assert property ($stable(event_out)[*3] ##0
		led_event != `RCS_LED_OFF |-> led_event ==
		(event_out ? `RCS_LED_RED : `RCS_LED_GREEN))
		else $error("event indicator wrong");
	a_sel_one: assert property (led_int_clock != `RCS_LED_OFF
		|-> led_ext_clock == `RCS_LED_OFF) else $error("both lit");
	a_sel_hold: assert property (host_sync[*8] |->
		(led_ext_clock == `RCS_LED_OFF) == $past(led_ext_clock == `RCS_LED_OFF))
		else $error("selection changed in run");
	a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_apb_err: assert property (pready |-> pslverr ==
		!(paddr == `RCS_OFF_CTRL || paddr == `RCS_OFF_STATUS))
		else $error("apb error flag wrong");
	a_apb_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("error read data not zero");
	a_int_pass: assert property (led_int_clock != `RCS_LED_OFF
		|-> experiment_timebase == timebase_clock)
		else $error("internal timebase not passed");
	// External source passes two sync stages and the output flop
	a_ext_pass: assert property (led_ext_clock != `RCS_LED_OFF
		|-> experiment_timebase == $past(ext_ref_clk, 3))
		else $error("external timebase not passed");
endmodule
bind rcs_top rcs_checker #(.HIGH_CYC(HIGH_CYC), .LOW_CYC(LOW_CYC)) u_chk (
	.ref_clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.host_sync, .partner_sync, .timebase_clock, .experiment_timebase,
	.ext_ref_clk, .event_out, .led_generator,
	.led_host_sync, .led_partner_sync, .led_int_clock, .led_ext_clock,
	.led_event);
`default_nettype wire

/* verif/rcs_host_model.sv */
// Host side of the setup bus and host sync line.
// Tasks are called from the bench; strobe idles high between writes.
`timescale 1ns/1ps
`default_nettype none
module rcs_host_model (
	input  wire logic       ref_clk,
	output logic            setup_strobe_n,
	output logic      [7:0] setup_bus,
	output logic            host_sync
);
	initial begin
		setup_strobe_n = 1'b1;
		setup_bus      = 8'h00;
		host_sync      = 1'b0;
	end
	task automatic set_run(input logic run);
		@(posedge ref_clk) host_sync <= run;
	endtask
	task automatic write_sel(input logic ext, input logic pol, input logic arm);
		@(posedge ref_clk) setup_bus <= {arm, 5'h00, pol, ext};
		repeat (3) @(posedge ref_clk);
		setup_strobe_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		setup_strobe_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// Bus no longer holds the value once the write is over
		setup_bus <= ~setup_bus;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* verif/test_rcs_top.sv */
// Bench for rcs_top: APB master, host model, pin stimulus.
// Short generator counts keep the run brief.
`timescale 1ns/1ps
`include "rcs_defines.svh"
`default_nettype none
module test_rcs_top;
	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, setup_bus;
	logic [31:0] pwdata, prdata, q;
	logic        setup_strobe_n, host_sync, partner_sync, e, ext_run, ext_lvl;
	logic        ext_ref_clk, ext_event, timebase_clock;
	logic        experiment_timebase, event_out;
	logic [1:0]  led_generator, led_host_sync, led_partner_sync;
	logic [1:0]  led_int_clock, led_ext_clock, led_event;
	int          n_checks, n_mismatch;
	rcs_top #(.HIGH_CYC(5), .LOW_CYC(6), .STUCK_CYC(30)) u_dut (
		.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .setup_strobe_n, .setup_bus, .host_sync,
		.partner_sync, .ext_ref_clk, .ext_event, .timebase_clock,
		.experiment_timebase, .event_out, .led_generator, .led_host_sync,
		.led_partner_sync, .led_int_clock, .led_ext_clock, .led_event);
	rcs_host_model u_host (.ref_clk, .setup_strobe_n, .setup_bus, .host_sync);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// External timebase of 16 cycles, well under the stuck limit;
	// parked at ext_lvl while stopped, so both stuck levels are reachable
	initial begin
		ext_ref_clk = 1'b0;
		forever begin
			repeat (8) @(posedge ref_clk);
			ext_ref_clk <= ext_run ? ~ext_ref_clk : ext_lvl;
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk) penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#60000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{partner_sync, ext_lvl, ext_event, ext_run} = 4'h0;
		{n_checks, n_mismatch} = 0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (30) @(posedge ref_clk);
		apb(1'b0, `RCS_OFF_STATUS, 32'h0);
		chk("sel_pol", 32'h2, q & 32'h3);
		chk("int_led", `RCS_LED_AMBER, led_int_clock);
		chk("gen_led", `RCS_LED_AMBER, led_generator);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		apb(1'b1, `RCS_OFF_CTRL, 32'h1);
		apb(1'b0, `RCS_OFF_CTRL, 32'h0);
		chk("ctrl", 32'h1, q);
		chk("blank_led", `RCS_LED_OFF, led_generator);
		apb(1'b1, `RCS_OFF_CTRL, 32'h0);
		$display("test apb done");
		ext_run <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			u_host.write_sel(1'b1, i[0], 1'b1);
			for (int v = 0; v < 2; v++) begin
				ext_event <= v[0];
				repeat (8) @(posedge ref_clk);
				chk("event", {31'h0, v[0] ~^ i[0]}, {31'h0, event_out});
				chk("event_led", (v[0] ~^ i[0]) ? `RCS_LED_RED : `RCS_LED_GREEN, led_event);
			end
			chk("ext_led", `RCS_LED_AMBER, led_ext_clock);
		end
		$display("test select done");
		ext_run <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			ext_lvl <= ~i[0];
			repeat (60) @(posedge ref_clk);
			chk("stuck", i ? `RCS_LED_GREEN : `RCS_LED_RED, led_ext_clock);
		end
		$display("test stuck done");
		u_host.set_run(1'b1);
		partner_sync <= 1'b1;
		u_host.write_sel(1'b0, 1'b1, 1'b1);
		chk("host_led", `RCS_LED_GREEN, led_host_sync);
		chk("partner_led", `RCS_LED_GREEN, led_partner_sync);
		apb(1'b0, `RCS_OFF_STATUS, 32'h0);
		chk("run_refused", 32'h3, q & 32'h3);
		u_host.set_run(1'b0);
		partner_sync <= 1'b0;
		// Idle bus afterwards reads armed, internal, polarity set: a level
		// latch would show 2, an ignored arm bit 1
		u_host.write_sel(1'b1, 1'b0, 1'b0);
		chk("host_led", `RCS_LED_RED, led_host_sync);
		chk("partner_led", `RCS_LED_RED, led_partner_sync);
		apb(1'b0, `RCS_OFF_STATUS, 32'h0);
		chk("arm_refused", 32'h3, q & 32'h3);
		u_host.write_sel(1'b0, 1'b1, 1'b1);
		apb(1'b0, `RCS_OFF_STATUS, 32'h0);
		chk("back_int", 32'h2, q & 32'h3);
		chk("int_led", `RCS_LED_AMBER, led_int_clock);
		$display("test refuse done");
		print_verdict;
	end
endmodule
`default_nettype wire
